// File: core/dmb_bank_addr.sv
// data memory bank addressing: ports, pointers, bank select, banked ram
//
// Contract
// - data space starts at 00h, registers lowest
// - register area identical in every bank
// - display memory in bank one only
// - port access redirected through paired pointer
// - first pair reaches bank zero only
// - second pair uses data bank field
// - pointer at a port: read zero, write nothing
// - pointers are ordinary read/write registers
// - direct accesses always go to bank zero
// - reset clears bank, except watchdog power-down (here it keeps the data bank field but still clears the code bank bits)
// - small variant: two-bit field, code 11 undefined
// - larger variants: three-bit field, 101-111 undefined
// - middle variant: bit five picks code bank
// - large variant: bits six-five pick code bank
// - one shared register for code and data banks
// - unimplemented bank bits read zero
// - unused register locations read zero
// - banked memory sits at 80h to ffh
//
// Chosen here: the AXI4-Lite interface to the registers.
`include "dmb_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dmb_bank_addr
    import dmb_pkg::*;
#(
    parameter dmb_variant_t VARIANT   = DMB_LARGE,
    parameter logic [7:0]   LCD_BYTES = `DMB_LCD_BYTES
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // processor core access, same clock
    input  wire logic        core_valid,
    input  wire dmb_acc_t    core_acc,
    output logic             core_done_r,
    output logic [7:0]       core_rdata_r,
    // reset sources other than aresetn
    input  wire logic        sys_rst_evt,
    input  wire logic        watchdog_pd_rst,
    // bank fields towards program and data paths
    output logic [2:0]       data_bank_field_r,
    output logic [1:0]       code_bank_field_r,
    // axi4-lite write address and data
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam logic [2:0] NBANK =
        (VARIANT == DMB_SMALL) ? `DMB_NBANK_SMALL : `DMB_NBANK_LARGE;
    localparam logic [7:0] BANK_MASK =
        (VARIANT == DMB_SMALL) ? `DMB_MASK_SMALL :
        (VARIANT == DMB_MID)   ? `DMB_MASK_MID : `DMB_MASK_LARGE;
    localparam int DEPTH = 128 * int'(NBANK);

    // only the upper half of each bank is storage
    logic [7:0] ram [0:DEPTH-1];

    logic [7:0] ptr_a_r;
    logic [7:0] ptr_b_r;
    logic [7:0] bank_select_r;

    // axi holding registers
    logic [7:0]  awidx_r;
    logic        awbad_r;
    logic        awv_r;
    logic [7:0]  wbyte_r;
    logic        wlane_r;
    logic        wv_r;
    logic [7:0]  aridx_r;
    logic        arbad_r;
    logic        arv_r;

    function automatic logic is_port(input logic [7:0] a);
        is_port = (a == `DMB_IDX_PORT_A) || (a == `DMB_IDX_PORT_B);
    endfunction

    // arbitration: core first, then bus write, then bus read
    dmb_grant_t grant;
    assign grant = core_valid ? GNT_CORE :
                   (awv_r && wv_r && !s_axi_bvalid) ? GNT_WR :
                   (arv_r && !s_axi_rvalid) ? GNT_RD : GNT_NONE;

    dmb_acc_t acc;
    assign acc = (grant == GNT_CORE) ? core_acc :
                 (grant == GNT_WR) ?
                     dmb_acc_t'{we: wlane_r && !awbad_r, addr: awidx_r, wdata: wbyte_r} :
                     dmb_acc_t'{we: 1'b0, addr: aridx_r, wdata: `DMB_ZERO8};
    wire acc_on = (grant != GNT_NONE);

    // address resolution
    wire       via_a = (acc.addr == `DMB_IDX_PORT_A);
    wire       via_b = (acc.addr == `DMB_IDX_PORT_B);
    wire [2:0] dbank = bank_select_r[`DMB_DBANK_LSB +: 3];
    wire       dbank_ok = (dbank < NBANK);
    wire [7:0] tgt = via_a ? ptr_a_r : via_b ? ptr_b_r : acc.addr;
    // only the second pair leaves bank zero
    wire [2:0] tbank = via_b ? dbank : `DMB_BANK0;
    wire       loop = (via_a || via_b) && is_port(tgt);
    wire       sfr = (tgt < `DMB_BANKED_BASE);
    wire [6:0] offs = tgt[6:0];
    wire       lcd_ok = (tbank != `DMB_LCD_BANK) || ({1'b0, offs} < LCD_BYTES);
    wire       bank_ok = !via_b || dbank_ok;
    wire       ram_hit = !sfr && !loop && bank_ok && lcd_ok;
    wire [9:0] ram_idx = {tbank, offs};

    logic [7:0] sfr_rd;
    always_comb begin
        case (tgt)
            `DMB_IDX_PTR_A: sfr_rd = ptr_a_r;
            `DMB_IDX_PTR_B: sfr_rd = ptr_b_r;
            `DMB_IDX_BANK:  sfr_rd = bank_select_r & BANK_MASK;
            default:        sfr_rd = `DMB_ZERO8;
        endcase
    end

    wire [7:0] rd_data = loop ? `DMB_ZERO8 :
                         sfr ? sfr_rd :
                         ram_hit ? ram[ram_idx] : `DMB_ZERO8;
    wire       wr_go = acc_on && acc.we && !loop;
    wire       wr_sfr = wr_go && sfr;
    wire       wr_ram = wr_go && ram_hit;

    // bank register next value; a reset event wins over a write
    wire [7:0] bank_wr = acc.wdata & BANK_MASK;
    wire [7:0] bank_keep = bank_select_r & BANK_MASK & 8'h07;
    logic [7:0] bank_nxt;
    always_comb begin
        bank_nxt = bank_select_r;
        if (wr_sfr && tgt == `DMB_IDX_BANK) begin
            bank_nxt = bank_wr;
        end
        if (sys_rst_evt) begin
            bank_nxt = watchdog_pd_rst ? bank_keep : `DMB_BANK_RST;
        end
    end

    // storage and pointers
    always_ff @(posedge aclk) begin
        if (wr_ram) begin
            ram[ram_idx] <= acc.wdata;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_a_r       <= `DMB_PTR_RST;
            ptr_b_r       <= `DMB_PTR_RST;
            bank_select_r <= `DMB_BANK_RST;
        end else begin
            if (wr_sfr && tgt == `DMB_IDX_PTR_A) begin
                ptr_a_r <= acc.wdata;
            end
            if (wr_sfr && tgt == `DMB_IDX_PTR_B) begin
                ptr_b_r <= acc.wdata;
            end
            bank_select_r <= bank_nxt;
        end
    end

    // bank fields out; code bank zero on the smallest variant
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_bank_field_r <= `DMB_BANK0;
            code_bank_field_r <= 2'b00;
        end else begin
            data_bank_field_r <= bank_nxt[`DMB_DBANK_LSB +: 3];
            code_bank_field_r <= bank_nxt[`DMB_CBANK_LSB +: 2];
        end
    end

    // core answer, one cycle after the request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_done_r  <= 1'b0;
            core_rdata_r <= `DMB_ZERO8;
        end else begin
            core_done_r <= (grant == GNT_CORE);
            if (grant == GNT_CORE) begin
                core_rdata_r <= rd_data;
            end
        end
    end

    // bus address decode: index in bits 9:2, upper bits must be zero
    wire aw_bad = (s_axi_awaddr[31:10] != `DMB_AXI_HI_ZERO);
    wire ar_bad = (s_axi_araddr[31:10] != `DMB_AXI_HI_ZERO);
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire b_done = s_axi_bvalid && s_axi_bready;
    wire r_done = s_axi_rvalid && s_axi_rready;

    // write channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awv_r         <= 1'b0;
            awidx_r       <= `DMB_ZERO8;
            awbad_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            wv_r          <= 1'b0;
            wbyte_r       <= `DMB_ZERO8;
            wlane_r       <= 1'b0;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `DMB_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awv_r         <= 1'b1;
                awidx_r       <= s_axi_awaddr[9:2];
                awbad_r       <= aw_bad;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wv_r         <= 1'b1;
                wbyte_r      <= s_axi_wdata[7:0];
                wlane_r      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (grant == GNT_WR) begin
                awv_r        <= 1'b0;
                wv_r         <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= awbad_r ? `DMB_RESP_SLVERR : `DMB_RESP_OKAY;
            end
            if (b_done) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel; upper data bits always zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arv_r         <= 1'b0;
            aridx_r       <= `DMB_ZERO8;
            arbad_r       <= 1'b0;
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `DMB_RESP_OKAY;
        end else begin
            if (ar_take) begin
                arv_r         <= 1'b1;
                aridx_r       <= s_axi_araddr[9:2];
                arbad_r       <= ar_bad;
                s_axi_arready <= 1'b0;
            end
            if (grant == GNT_RD) begin
                arv_r        <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, arbad_r ? `DMB_ZERO8 : rd_data};
                s_axi_rresp  <= arbad_r ? `DMB_RESP_SLVERR : `DMB_RESP_OKAY;
            end
            if (r_done) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: core/dmb_defines.svh
// offsets, field positions, reset values and sizes of the bank addressing block
`ifndef DMB_DEFINES_SVH
`define DMB_DEFINES_SVH
// register indices; bus byte address is four times the index
`define DMB_IDX_PORT_A   8'h00
`define DMB_IDX_PTR_A    8'h01
`define DMB_IDX_PORT_B   8'h02
`define DMB_IDX_PTR_B    8'h03
`define DMB_IDX_BANK     8'h04
`define DMB_SFR_BASE     8'h00
`define DMB_BANKED_BASE  8'h80
`define DMB_BANK_RST     8'h00
`define DMB_PTR_RST      8'h00
`define DMB_MASK_SMALL   8'h03
`define DMB_MASK_MID     8'h27
`define DMB_MASK_LARGE   8'h67
`define DMB_DBANK_LSB    0
`define DMB_CBANK_LSB    5
`define DMB_NBANK_SMALL  3'd3
`define DMB_NBANK_LARGE  3'd5
`define DMB_BANK0        3'd0
`define DMB_LCD_BANK     3'd1
`define DMB_LCD_BYTES    8'h20
`define DMB_AXI_HI_ZERO  22'h000000
`define DMB_RESP_OKAY    2'b00
`define DMB_RESP_SLVERR  2'b10
`define DMB_ZERO8        8'h00
`endif

// File: core/dmb_pkg.sv
// types of the bank addressing block
package dmb_pkg;
    typedef enum logic [1:0] {
        DMB_SMALL = 2'b00,
        DMB_MID   = 2'b01,
        DMB_LARGE = 2'b10
    } dmb_variant_t;

    typedef enum logic [1:0] {
        GNT_NONE = 2'b00,
        GNT_CORE = 2'b01,
        GNT_WR   = 2'b10,
        GNT_RD   = 2'b11
    } dmb_grant_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmb_acc_t;
endpackage

// File: verification/dmb_core_model.sv
// processor core stand-in issuing byte accesses
`timescale 1ns/1ps
`default_nettype none
module dmb_core_model
    import dmb_pkg::*;
(
    // clock
    input  wire logic       aclk,
    // access side
    output var logic        core_valid,
    output var dmb_acc_t    core_acc,
    input  wire logic       core_done_r,
    input  wire logic [7:0] core_rdata_r
);
    initial begin
        core_valid = 1'b0;
        core_acc   = '0;
    end
    // payload inverted when idle so stale values never help
    task automatic acc(input logic we, input logic [7:0] a, input logic [7:0] v, output logic [7:0] q);
        core_valid <= 1'b1;
        core_acc   <= '{we, a, v};
        @(posedge aclk);
        core_valid <= 1'b0;
        core_acc   <= ~core_acc;
        do @(posedge aclk); while (core_done_r !== 1'b1);
        q = core_rdata_r;
    endtask
endmodule
`default_nettype wire

// File: verification/dmb_bank_addr_asserts.sv
// concurrent checks on the bank addressing ports
`timescale 1ns/1ps
`default_nettype none
module dmb_bank_addr_asserts (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // core side
    input wire logic        core_valid,
    input wire logic        core_done_r,
    input wire logic [7:0]  core_rdata_r,
    // reset events and bank fields
    input wire logic        sys_rst_evt,
    input wire logic        watchdog_pd_rst,
    input wire logic [2:0]  data_bank_field_r,
    input wire logic [1:0]  code_bank_field_r,
    // bus side
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wd_evt;
        sys_rst_evt && watchdog_pd_rst;
    endsequence
    sequence s_chip_evt;
        sys_rst_evt && !watchdog_pd_rst;
    endsequence
    a_core_answer: assert property (core_valid |=> core_done_r)
        else $error("core access not answered");
    a_core_quiet: assert property (!core_valid |=> !core_done_r)
        else $error("core done without request");
    a_rdata_hold: assert property (!core_valid |=> $stable(core_rdata_r))
        else $error("core read data moved");
    a_bank_clear: assert property (s_chip_evt |=> data_bank_field_r == 3'h0)
        else $error("data bank not cleared");
    // power-down watchdog must not lose the data bank
    a_bank_keep: assert property (s_wd_evt |=> $stable(data_bank_field_r))
        else $error("data bank lost");
    a_code_clear: assert property (sys_rst_evt |=> code_bank_field_r == 2'h0)
        else $error("code bank not cleared");
    a_rd_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response stuck");
    a_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits set");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// top testbench of the bank addressing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dmb_pkg::*;
    logic        aclk, aresetn, core_valid, core_done_r, sys_rst_evt, watchdog_pd_rst;
    dmb_acc_t    core_acc;
    logic [7:0]  core_rdata_r, q;
    logic [2:0]  data_bank_field_r;
    logic [1:0]  code_bank_field_r, s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int          failures, n_checks, cyc;
    dmb_bank_addr dmb_bank_addr_inst (.*);
    dmb_core_model dmb_core_model_inst (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    // address and data offered together, each dropped once taken
    task wr(input logic [7:0] i, input logic [7:0] v);
        s_axi_awaddr <= {22'h0, i, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task rd(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task rc(input logic [7:0] i, input logic [7:0] e);
        rd({22'h0, i, 2'b00});
        chk("bus read", d, {24'h0, e});
    endtask
    task cw(input logic [7:0] a, input logic [7:0] v);
        dmb_core_model_inst.acc(1'b1, a, v, q);
    endtask
    task cc(input logic [7:0] a, input logic [7:0] e);
        dmb_core_model_inst.acc(1'b0, a, 8'h00, q);
        chk("core read", {24'h0, q}, {24'h0, e});
    endtask
    task ev(input logic wd);
        sys_rst_evt <= 1'b1;
        watchdog_pd_rst <= wd;
        @(posedge aclk);
        sys_rst_evt <= 1'b0;
        @(posedge aclk);
    endtask
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            stop_test();
        end
    end
    initial begin
        {aresetn, sys_rst_evt, watchdog_pd_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hf;
        {failures, n_checks, cyc} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(8'h04, 8'h00);
        rc(8'h03, 8'h00);
        wr(8'h04, 8'hff);
        rc(8'h04, 8'h67);
        chk("code bank", {30'h0, code_bank_field_r}, 32'h3);
        wr(8'h04, 8'h02);
        chk("code bank", {30'h0, code_bank_field_r}, 32'h0);
        cw(8'h90, 8'h5a);
        rc(8'h90, 8'h5a);
        wr(8'h03, 8'h90);
        cw(8'h02, 8'h33);
        rc(8'h90, 8'h5a);
        cc(8'h02, 8'h33);
        wr(8'h01, 8'h90);
        cc(8'h00, 8'h5a);
        wr(8'h03, 8'h01);
        cc(8'h02, 8'h90);
        wr(8'h01, 8'h02);
        cw(8'h00, 8'h77);
        cc(8'h00, 8'h00);
        rc(8'h03, 8'h01);
        wr(8'h04, 8'h01);
        wr(8'h03, 8'ha0);
        cw(8'h02, 8'h44);
        cc(8'h02, 8'h00);
        wr(8'h03, 8'h85);
        cw(8'h02, 8'h55);
        cc(8'h02, 8'h55);
        wr(8'h04, 8'h05);
        cw(8'h02, 8'h66);
        cc(8'h02, 8'h00);
        wr(8'h04, 8'h63);
        ev(1'b1);
        chk("data bank", {29'h0, data_bank_field_r}, 32'h3);
        chk("code bank", {30'h0, code_bank_field_r}, 32'h0);
        ev(1'b0);
        chk("data bank", {29'h0, data_bank_field_r}, 32'h0);
        wr(8'h10, 8'haa);
        rc(8'h10, 8'h00);
        rd(32'h0000_0400);
        chk("bad address resp", {30'h0, rsp}, 32'h2);
        stop_test();
    end
endmodule
bind dmb_bank_addr dmb_bank_addr_asserts dmb_bank_addr_asserts_inst (.*);
`default_nettype wire
